/* File: core/hsc_pkg.sv */
// constants, field layout and carrier types for the serdes control register bank
package hsc_pkg;

  // management frame layout
  localparam logic [5:0]  PREAMBLE_LEN   = 6'h20;
  localparam logic [5:0]  HDR_LAST_BIT   = 6'h0b;
  localparam logic [5:0]  DATA_LAST_BIT  = 6'h0f;
  localparam logic [1:0]  OP_ADDRESS     = 2'h0;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [1:0]  OP_READ_INC    = 2'h2;
  localparam logic [1:0]  OP_READ        = 2'h3;
  localparam logic [4:0]  SERDES_DEVAD   = 5'h1e;

  // register addresses inside the device
  localparam logic [15:0] ADDR_GLOBAL    = 16'h0001;
  localparam logic [15:0] ADDR_PLL_CTL   = 16'h0002;
  localparam logic [15:0] ADDR_TXRX_CTL  = 16'h0003;

  // reset values
  localparam logic [15:0] RST_GLOBAL     = 16'h0000;
  localparam logic [15:0] RST_PLL_CTL    = 16'h831d;
  localparam logic [15:0] RST_TXRX_CTL   = 16'ha848;
  localparam logic [15:0] RST_ADDR       = 16'h0000;

  // field positions
  localparam int GLOBAL_PD_BIT   = 15;
  localparam int PLL_BW_LSB      = 8;
  localparam int VCO_RANGE_BIT   = 6;
  localparam int PLL_EN_BIT      = 4;
  localparam int PLL_MULT_LSB    = 0;
  localparam int TX_SWING_LSB    = 12;
  localparam int TX_EN_BIT       = 11;
  localparam int EQ_HOLD_BIT     = 10;
  localparam int TX_RATE_LSB     = 8;
  localparam int GAIN_MODE_LSB   = 6;
  localparam int AZ_CAL_LSB      = 4;

  // frame receiver states
  typedef enum logic [2:0] {
    ST_PRE   = 3'b000,
    ST_START = 3'b001,
    ST_HDR   = 3'b010,
    ST_TA    = 3'b011,
    ST_DATA  = 3'b100
  } hsc_mdio_st_t;

  // control bundle toward the analog macro
  typedef struct packed {
    logic [1:0] pll_loop_bw_sel;
    logic       vco_low_range;
    logic       pll_enable;
    logic [3:0] pll_multiplier_code;
    logic [3:0] tx_output_swing;
    logic       tx_enable;
    logic       equalizer_hold;
    logic [1:0] tx_rate_sel;
    logic [1:0] gain_loop_mode;
    logic [1:0] auto_zero_cal_mode;
    logic       global_power_down;
  } hsc_serdes_ctl_t;

endpackage

/* File: core/hsc_regs.sv */
// mdio clause 45 slave holding the serdes pll and tx/rx control registers
// Behaviour
// - two-bit pll loop bandwidth field, medium/low/high/ultra, resets to ultra high.
// - vco range bit: zero upper range (reset), one lower range.
// - pll enable bit resets to one; pin low or global global_power_down forces pll off.
// - four-bit pll multiplier code, 0000/0001/1111 reserved, resets to 1101.
// - reserved bits of first register are read-write with their reset values.
// - first control register at device 0x1e, register 0x0002, resets 0x831d.
// - four-bit tx swing field in bits 15:12 of second register, resets 1010.
// - tx enable bit resets to one; pin low or global global_power_down forces tx off.
// - equalizer hold bit freezes equalizer and long tail correction when one.
// - two-bit tx rate: full, half, quarter, eighth; resets to full.
// - two-bit gain loop mode field, four modes, resets to 01.
// - two-bit auto-zero calibration mode field, four modes, resets to 00.
// - global global_power_down bit powers down datapath; management interface keeps running.
`timescale 1ns/10ps

module hsc_regs (
  // clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     arst_n_in,
  // management pins
  input  wire logic                     mdc_in,
  input  wire logic                     mdio_in,
  output logic                          mdio_out,
  output logic                          mdio_oe_out,
  input  wire logic [4:0]               phy_addr_in,
  // channel power pin
  input  wire logic                     channel_pwrdn_n_in,
  // analog macro controls
  output hsc_pkg::hsc_serdes_ctl_t      serdes_ctl_out
);

  typedef struct packed {
    hsc_pkg::hsc_mdio_st_t     st;
    logic [5:0]                cnt;
    logic [11:0]               hdr;
    logic [15:0]               sh;
    logic [15:0]               addr;
    logic                      match;
    logic [15:0]               global_ctl;
    logic [15:0]               pll_ctl;
    logic [15:0]               txrx_ctl;
    logic                      mdc_prev;
    logic                      mdio_out;
    logic                      mdio_oe;
    hsc_pkg::hsc_serdes_ctl_t  ctl;
  } hsc_state_t;

  localparam hsc_state_t STATE_RST = '{
    st:         hsc_pkg::ST_PRE,
    cnt:        6'h00,
    hdr:        12'h000,
    sh:         16'h0000,
    addr:       hsc_pkg::RST_ADDR,
    match:      1'b0,
    global_ctl: hsc_pkg::RST_GLOBAL,
    pll_ctl:    hsc_pkg::RST_PLL_CTL,
    txrx_ctl:   hsc_pkg::RST_TXRX_CTL,
    mdc_prev:   1'b0,
    mdio_out:   1'b0,
    mdio_oe:    1'b0,
    ctl:        '0
  };

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0]  rst_sync_q;
  logic        rst_n;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // unmapped addresses read as zero; only the global_power_down bit exists at the global address
  function automatic logic [15:0] reg_read(input hsc_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    case (s.addr)
      hsc_pkg::ADDR_GLOBAL:   v[hsc_pkg::GLOBAL_PD_BIT] = s.global_ctl[hsc_pkg::GLOBAL_PD_BIT];
      hsc_pkg::ADDR_PLL_CTL:  v = s.pll_ctl;
      hsc_pkg::ADDR_TXRX_CTL: v = s.txrx_ctl;
      default:                v = 16'h0000;
    endcase
    return v;
  endfunction

  function automatic logic is_read(input logic [1:0] op);
    return (op == hsc_pkg::OP_READ) || (op == hsc_pkg::OP_READ_INC);
  endfunction

  // address frames only move the held pointer
  function automatic logic is_addr(input logic [1:0] op);
    return op == hsc_pkg::OP_ADDRESS;
  endfunction

  function automatic logic is_write(input logic [1:0] op);
    return op == hsc_pkg::OP_WRITE;
  endfunction

  // frame is ours: port address from the pins, device address fixed
  function automatic logic frame_hits(input logic [11:0] hdr, input logic [4:0] port);
    return (hdr[9:5] == port) && (hdr[4:0] == hsc_pkg::SERDES_DEVAD);
  endfunction

  // next read bit onto the pin, rest of the word moved up
  function automatic hsc_state_t shift_out(input hsc_state_t s);
    hsc_state_t r;
    r          = s;
    r.mdio_out = s.sh[15];
    r.sh       = {s.sh[14:0], 1'b0};
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register write and field decode

  // write lands under the held address; unmapped addresses drop it
  function automatic hsc_state_t reg_write(input hsc_state_t s, input logic [15:0] v);
    hsc_state_t r;
    r = s;
    case (s.addr)
      hsc_pkg::ADDR_GLOBAL: begin
        // only the global_power_down bit is stored at this address
        r.global_ctl[hsc_pkg::GLOBAL_PD_BIT] = v[hsc_pkg::GLOBAL_PD_BIT];
      end
      hsc_pkg::ADDR_PLL_CTL: begin
        r.pll_ctl = v;
      end
      hsc_pkg::ADDR_TXRX_CTL: begin
        r.txrx_ctl = v;
      end
      default: begin
        r.pll_ctl = s.pll_ctl;
      end
    endcase
    return r;
  endfunction

  // enables are gated by power so the macro never sees a stale enable in global_power_down
  function automatic hsc_pkg::hsc_serdes_ctl_t ctl_decode(input logic [15:0] pll,
                                                          input logic [15:0] txrx,
                                                          input logic        gpd,
                                                          input logic        pin_n);
    hsc_pkg::hsc_serdes_ctl_t c;
    logic                     on;
    on                    = pin_n & ~gpd;
    c.pll_loop_bw_sel     = pll[hsc_pkg::PLL_BW_LSB +: 2];
    c.vco_low_range       = pll[hsc_pkg::VCO_RANGE_BIT];
    c.pll_enable          = pll[hsc_pkg::PLL_EN_BIT] & on;
    c.pll_multiplier_code = pll[hsc_pkg::PLL_MULT_LSB +: 4];
    c.tx_output_swing     = txrx[hsc_pkg::TX_SWING_LSB +: 4];
    c.tx_enable           = txrx[hsc_pkg::TX_EN_BIT] & on;
    c.equalizer_hold      = txrx[hsc_pkg::EQ_HOLD_BIT];
    c.tx_rate_sel         = txrx[hsc_pkg::TX_RATE_LSB +: 2];
    c.gain_loop_mode      = txrx[hsc_pkg::GAIN_MODE_LSB +: 2];
    c.auto_zero_cal_mode  = txrx[hsc_pkg::AZ_CAL_LSB +: 2];
    c.global_power_down   = gpd;
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  hsc_state_t  q;
  hsc_state_t  d;
  logic        mdc_rise;
  logic [11:0] hdr_n;
  logic [15:0] sh_n;
  logic        rd;

  // mdc is a slow plain input: a rise is seen as long as each level lasts at least one clock
  // limitation: a cut frame is only left once its remaining rises have been counted
  assign mdc_rise = mdc_in & ~q.mdc_prev;
  assign hdr_n    = {q.hdr[10:0], mdio_in};
  assign sh_n     = {q.sh[14:0], mdio_in};
  assign rd       = is_read(q.hdr[11:10]);

  always_comb begin
    d          = q;
    d.mdc_prev = mdc_in;
    if (mdc_rise) begin
      case (q.st)
        hsc_pkg::ST_PRE: begin
          if (mdio_in) begin
            if (q.cnt != hsc_pkg::PREAMBLE_LEN) begin
              d.cnt = q.cnt + 6'h01;
            end
          end else if (q.cnt == hsc_pkg::PREAMBLE_LEN) begin
            d.st  = hsc_pkg::ST_START;
            d.cnt = 6'h00;
          end else begin
            d.cnt = 6'h00;
          end
        end
        hsc_pkg::ST_START: begin
          // a one here is a clause 22 start; such frames are not answered
          d.cnt = 6'h00;
          d.st  = mdio_in ? hsc_pkg::ST_PRE : hsc_pkg::ST_HDR;
        end
        hsc_pkg::ST_HDR: begin
          d.hdr = hdr_n;
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == hsc_pkg::HDR_LAST_BIT) begin
            d.cnt   = 6'h00;
            d.st    = hsc_pkg::ST_TA;
            d.match = frame_hits(hdr_n, phy_addr_in);
            if (is_read(hdr_n[11:10]) && d.match) begin
              d.sh = reg_read(q);
              if (hdr_n[11:10] == hsc_pkg::OP_READ_INC) begin
                d.addr = q.addr + 16'h0001;
              end
            end
          end
        end
        hsc_pkg::ST_TA: begin
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == 6'h00) begin
            if (rd && q.match) begin
              d.mdio_oe  = 1'b1;
              d.mdio_out = 1'b0;
            end
          end else begin
            d.cnt = 6'h00;
            d.st  = hsc_pkg::ST_DATA;
            if (rd && q.match) begin
              d = shift_out(d);
            end
          end
        end
        hsc_pkg::ST_DATA: begin
          d.cnt = q.cnt + 6'h01;
          if (rd) begin
            if (q.match && (q.cnt != hsc_pkg::DATA_LAST_BIT)) begin
              d = shift_out(d);
            end
          end else begin
            d.sh = sh_n;
          end
          if (q.cnt == hsc_pkg::DATA_LAST_BIT) begin
            d.st       = hsc_pkg::ST_PRE;
            d.cnt      = 6'h00;
            d.mdio_oe  = 1'b0;
            d.mdio_out = 1'b0;
            if (q.match && is_addr(q.hdr[11:10])) begin
              d.addr = sh_n;
            end
            if (q.match && is_write(q.hdr[11:10])) begin
              d = reg_write(d, sh_n);
            end
          end
        end
        default: begin
          d.st  = hsc_pkg::ST_PRE;
          d.cnt = 6'h00;
        end
      endcase
    end

    // macro controls follow the freshly written values in the same edge
    d.ctl = ctl_decode(d.pll_ctl, d.txrx_ctl, d.global_ctl[hsc_pkg::GLOBAL_PD_BIT], channel_pwrdn_n_in);
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign mdio_out       = q.mdio_out;
  assign mdio_oe_out    = q.mdio_oe;
  assign serdes_ctl_out = q.ctl;

endmodule

/* File: sim/hsc_regs_properties.sv */
// concurrent checks on the serdes control register bank ports
`timescale 1ns/10ps
module hsc_regs_checker (
  // watched pins
  input wire logic                ref_clk_in,
  input wire logic                arst_n_in,
  input wire logic                mdc_in,
  input wire logic                mdio_out,
  input wire logic                mdio_oe_out,
  input wire logic                channel_pwrdn_n_in,
  input hsc_pkg::hsc_serdes_ctl_t serdes_ctl_out
);
  logic [2:0]               up_q;
  logic [1:0]               ens;
  hsc_pkg::hsc_serdes_ctl_t cfg;
  assign ens = {serdes_ctl_out.pll_enable, serdes_ctl_out.tx_enable};
  // enables masked: they also follow the pin, which needs no mdc edge
  always_comb begin
    cfg = serdes_ctl_out;
    cfg.pll_enable = 1'b0;
    cfg.tx_enable = 1'b0;
  end
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  ////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  a_pll_pin_off: assert property (!channel_pwrdn_n_in |=> !ens[1])
    else $error("pll on with pin low");
  a_tx_pin_off: assert property (!channel_pwrdn_n_in |=> !ens[0])
    else $error("tx on with pin low");
  a_gpd_off: assert property (cfg.global_power_down |-> ens == 2'h0)
    else $error("enable on in global global_power_down");
  a_cfg_on_mdc: assert property (up_q == 3'h7 && $changed(cfg) |-> $past(mdc_in) && !$past(mdc_in, 2))
    else $error("field moved without mdc rise");
  a_oe_on_mdc: assert property ($changed(mdio_oe_out) |-> $past(mdc_in) && !$past(mdc_in, 2))
    else $error("drive moved without mdc rise");
  a_out_idle: assert property (!mdio_oe_out |-> !mdio_out)
    else $error("data high while not driving");
  a_oe_holds: assert property ($rose(mdio_oe_out) |-> mdio_oe_out [*8])
    else $error("drive window too short");
  a_reset_cfg: assert property (up_q == 3'h5 |-> cfg == 21'h19b408)
    else $error("fields not at reset values");
endmodule
bind hsc_regs hsc_regs_checker chk (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .mdc_in(mdc_in),
  .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out), .channel_pwrdn_n_in(channel_pwrdn_n_in),
  .serdes_ctl_out(serdes_ctl_out));

/* File: sim/hsc_station.sv */
// mdio management station sending clause 45 frames
`timescale 1ns/10ps
module hsc_station (
  // clock and device pins
  input  wire logic clk_in,
  input  wire logic dev_out_in,
  input  wire logic dev_oe_in,
  // bus lines
  output logic      mdc_out,
  output logic      line_out
);
  logic drv_q = 1'b1;
  logic en_q = 1'b0;
  logic smp;
  initial mdc_out = 1'b0;
  // pull-up: a released line reads one
  assign line_out = dev_oe_in ? dev_out_in : (en_q ? drv_q : 1'b1);
  ////////////////////////////////
  // two clocks low, two high; sample just before the rise
  task automatic bit_cycle(input logic en, input logic b);
    @(posedge clk_in);
    mdc_out <= 1'b0;
    en_q <= en;
    drv_q <= b;
    repeat (2) @(posedge clk_in);
    smp = line_out;
    mdc_out <= 1'b1;
    @(posedge clk_in);
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] ph, input logic [4:0] dv,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] hd;
    hd = {2'b00, op, ph, dv, 2'b10, wd};
    for (int k = 0; k < 32; k++) bit_cycle(1'b1, 1'b1);
    for (int k = 0; k < 32; k++) begin
      bit_cycle(!(op[1] && k > 13), hd[31-k]);
      if (k > 15) rd[31-k] = smp;
    end
  endtask
endmodule

/* File: sim/hsc_regs_test.sv */
// self-checking bench for the serdes control register bank
`timescale 1ns/10ps
module hsc_regs_test;
  logic                     clk = 1'b0;
  logic                     arst_n = 1'b0;
  logic                     pin_n = 1'b1;
  logic [4:0]               ph = 5'h05;
  logic [4:0]               dv = 5'h1e;
  logic                     mdc, line, d_out, d_oe;
  logic [15:0]              r, d;
  hsc_pkg::hsc_serdes_ctl_t ctl;
  int                       miscompares = 0;
  int                       n_compared = 0;
  always #20 clk = ~clk;
  hsc_station stn (.clk_in(clk), .dev_out_in(d_out), .dev_oe_in(d_oe), .mdc_out(mdc), .line_out(line));
  hsc_regs dut (.ref_clk_in(clk), .arst_n_in(arst_n), .mdc_in(mdc), .mdio_in(line), .mdio_out(d_out),
    .mdio_oe_out(d_oe), .phy_addr_in(5'h05), .channel_pwrdn_n_in(pin_n), .serdes_ctl_out(ctl));
  ////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // address frame then write; two clocks let the update land
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    stn.frame(hsc_pkg::OP_ADDRESS, ph, dv, a, r);
    stn.frame(hsc_pkg::OP_WRITE, ph, dv, v, r);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    stn.frame(hsc_pkg::OP_ADDRESS, ph, dv, a, r);
    stn.frame(hsc_pkg::OP_READ, ph, dv, 16'h0000, r);
  endtask
  task automatic chk_ctl(input logic [15:0] p, input logic [15:0] t, input logic en);
    check("bw", ctl.pll_loop_bw_sel, p[9:8]);
    check("vco", ctl.vco_low_range, p[6]);
    check("pll", ctl.pll_enable, p[4] & en);
    check("mul", ctl.pll_multiplier_code, p[3:0]);
    check("sw", ctl.tx_output_swing, t[15:12]);
    check("tx", ctl.tx_enable, t[11] & en);
    check("eq", ctl.equalizer_hold, t[10]);
    check("rt", ctl.tx_rate_sel, t[9:8]);
    check("gn", ctl.gain_loop_mode, t[7:6]);
    check("az", ctl.auto_zero_cal_mode, t[5:4]);
  endtask
  ////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk_ctl(16'h831d, 16'ha848, 1'b1);
    rd(16'h0002);
    check("pll_reg", r, 16'h831d);
    rd(16'h0003);
    check("txrx_reg", r, 16'ha848);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      d = {4{4'(i)}};
      wr(16'h0002, d);
      wr(16'h0003, ~d);
      chk_ctl(d, ~d, 1'b1);
      rd(16'h0002);
      check("pll_rw", r, d);
      rd(16'h0003);
      check("txrx_rw", r, ~d);
    end
    $display("field test done");
    wr(16'h0003, 16'ha848);
    wr(16'h0002, 16'h8352);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_ctl(16'h8352, 16'ha848, 1'b0);
    @(posedge clk);
    pin_n <= 1'b1;
    wr(16'h0001, 16'hffff);
    chk_ctl(16'h8352, 16'ha848, 1'b0);
    check("gpd", ctl.global_power_down, 1'b1);
    rd(16'h0001);
    check("gpd_reg", r, 16'h8000);
    wr(16'h0001, 16'h0000);
    $display("global_power_down test done");
    ph = 5'h06;
    wr(16'h0002, 16'h0000);
    ph = 5'h05;
    dv = 5'h1f;
    wr(16'h0002, 16'h0000);
    dv = 5'h1e;
    wr(16'h0010, 16'hffff);
    chk_ctl(16'h8352, 16'ha848, 1'b1);
    rd(16'h0010);
    check("unmapped", r, 16'h0000);
    stn.frame(hsc_pkg::OP_ADDRESS, ph, dv, 16'h0002, r);
    stn.frame(hsc_pkg::OP_READ_INC, ph, dv, 16'h0000, r);
    check("rd_inc", r, 16'h8352);
    stn.frame(hsc_pkg::OP_READ, ph, dv, 16'h0000, r);
    check("rd_next", r, 16'ha848);
    $display("refusal test done");
    test_done();
  end
endmodule
